// ==== logic/pixel_control_regs.v ====
// Pixel control register bank of the video decoder with its Wishbone slave and pixel path
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "pixel_control_regs.vh"

module pixel_control_regs #(
  parameter LINE_W = 10                            // Width of line numbers
) (
  input  wire              clk_i,                  // 20 MHz clock
  input  wire              rst_i,                  // Synchronous reset, active high
  input  wire              wb_cyc_i,               // Wishbone cycle
  input  wire              wb_stb_i,               // Wishbone strobe
  input  wire              wb_we_i,                // Wishbone write enable
  input  wire [6:0]        wb_adr_i,               // Byte address
  input  wire [3:0]        wb_sel_i,               // Byte selects
  input  wire [31:0]       wb_dat_i,               // Write data
  output reg  [31:0]       wb_dat_o,               // Read data
  output reg               wb_ack_o,               // Acknowledge
  input  wire [7:0]        luma_i,                 // Decoded luma sample
  input  wire [7:0]        chroma_i,               // Decoded chroma, two's complement
  input  wire [7:0]        luma_2x_i,              // Second double-rate luma sample
  input  wire [7:0]        decimated_i,            // Decimation filter output
  input  wire [7:0]        raw_sample_i,           // Raw converter sample
  input  wire              anc_slot_i,             // Ancillary header byte slot
  input  wire [7:0]        anc_header_i,           // Standard ancillary header byte
  input  wire              horizontal_blank_region_i, // Horizontal blanking
  input  wire [LINE_W-1:0] line_i,                 // Current line number
  input  wire [LINE_W-1:0] std_blank_start_i,      // Standard blanking first line
  input  wire [LINE_W-1:0] std_blank_stop_i,       // Standard blanking end line
  input  wire              secam_i,                // SECAM being decoded
  input  wire              active_video_i,         // Raw active video indication
  input  wire              field_id_i,             // Field identifier
  input  wire              genlock_i,              // Genlock serial output
  input  wire              lock_i,                 // Horizontal and vertical lock
  input  wire              vsync_i,                // Vertical sync
  input  wire              pal_i,                  // PAL line indicator
  input  wire              irq_i,                  // Interrupt request
  input  wire              gp_level_i,             // General-purpose pin level
  input  wire              clk_2x_i,               // Double-rate sample clock
  input  wire              clk_1x_i,               // Pixel-rate clock
  output reg  [7:0]        pixel_y_o,              // Output luma byte
  output reg  [7:0]        pixel_c_o,              // Output chroma or second luma byte
  output reg               luma_2x_active_o,       // Double-rate luma mode selected
  output reg               embedded_sync_o,        // Embedded sync format chosen
  output reg               format_reserved_o,      // Reserved format or path code
  output reg               active_video_flag_o,    // Gated active video flag
  output reg               field_identifier_out_o, // First shared pin
  output reg               pal_indicator_out_o,    // Second shared pin
  output reg               interrupt_request_out_o, // Third shared pin
  output wire              clock_out_o,            // Clock pin
  output reg  [2:0]        peaking_gain_o,         // Gain in halves: 0,1,2,4
  output reg               trap_filter_o,          // 1 trap filter, 0 comb
  output reg               agc_force_o,            // Pulse detection forced
  output reg               agc_force_on_o,         // Forced level when forced
  output reg  [1:0]        notch_select_o,         // Trap stopband select
  output reg               wide_notch_select_o,    // Wide stopband set
  output reg               pedestal_present_o,     // Setup pedestal present
  output reg  [7:0]        hue_phase_o,            // Effective hue phase
  output reg  [9:0]        crop_start_o,           // Applied crop start offset
  output reg               vertical_blank_out_o    // Adjusted blanking window
);

  reg [7:0] misc_pin_reg;
  reg [7:0] luma_one_reg;
  reg [7:0] luma_two_reg;
  reg [7:0] bright_reg;
  reg [7:0] sat_reg;
  reg [7:0] hue_reg;
  reg [7:0] contrast_reg;
  reg [7:0] format_reg;
  reg [7:0] luma_three_reg;
  reg [7:0] shared_reg;
  reg [7:0] crop_high_reg;
  reg [7:0] crop_low_reg;
  reg [7:0] blank_start_reg;
  reg [7:0] blank_stop_reg;
  reg [7:0] notch_width_reg;

  wire [4:0] idx      = wb_adr_i[6:2];
  wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr_lane0 = req & wb_we_i & wb_sel_i[0];

  function is_write;
    input [4:0] a;
    input [4:0] target;
    input       lane;
    begin
      is_write = lane && (a == target);
    end
  endfunction

  // Register writes; every bank register is plain read/write
  always @(posedge clk_i) begin
    if (rst_i) begin
      misc_pin_reg    <= `RST_MISC_PIN_SELECT;
      luma_one_reg    <= `RST_LUMA_CTL_ONE;
      luma_two_reg    <= `RST_LUMA_CTL_TWO;
      bright_reg      <= `RST_BRIGHTNESS;
      sat_reg         <= `RST_SATURATION;
      hue_reg         <= `RST_HUE;
      contrast_reg    <= `RST_CONTRAST;
      format_reg      <= `RST_OUTPUT_FORMAT;
      luma_three_reg  <= `RST_LUMA_CTL_THREE;
      shared_reg      <= `RST_SHARED_PIN;
      crop_high_reg   <= `RST_CROP_START_HIGH;
      crop_low_reg    <= `RST_CROP_START_LOW;
      blank_start_reg <= `RST_BLANK_START;
      blank_stop_reg  <= `RST_BLANK_STOP;
      notch_width_reg <= `RST_NOTCH_WIDTH;
      crop_start_o    <= 10'h000;
    end else begin
      if (is_write(idx, `IDX_MISC_PIN_SELECT, wr_lane0))
        misc_pin_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_LUMA_CTL_ONE, wr_lane0))
        luma_one_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_LUMA_CTL_TWO, wr_lane0))
        luma_two_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_BRIGHTNESS, wr_lane0))
        bright_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_SATURATION, wr_lane0))
        sat_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_HUE, wr_lane0))
        hue_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_CONTRAST, wr_lane0))
        contrast_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_OUTPUT_FORMAT, wr_lane0))
        format_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_LUMA_CTL_THREE, wr_lane0))
        luma_three_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_SHARED_PIN, wr_lane0))
        shared_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_CROP_START_HIGH, wr_lane0))
        crop_high_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_CROP_START_LOW, wr_lane0)) begin
        crop_low_reg <= wb_dat_i[7:0];
        // High byte is only staged; the pair takes effect here
        crop_start_o <= {crop_high_reg, wb_dat_i[1:0]};
      end
      if (is_write(idx, `IDX_BLANK_START, wr_lane0))
        blank_start_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_BLANK_STOP, wr_lane0))
        blank_stop_reg <= wb_dat_i[7:0];
      if (is_write(idx, `IDX_NOTCH_WIDTH, wr_lane0))
        notch_width_reg <= wb_dat_i[7:0];
    end
  end

  // Read decode; unmapped indices read zero and still acknowledge
  reg [7:0] rd_byte;
  always @* begin
    if (idx == `IDX_MISC_PIN_SELECT)
      rd_byte = misc_pin_reg;
    else if (idx == `IDX_LUMA_CTL_ONE)
      rd_byte = luma_one_reg;
    else if (idx == `IDX_LUMA_CTL_TWO)
      rd_byte = luma_two_reg;
    else if (idx == `IDX_BRIGHTNESS)
      rd_byte = bright_reg;
    else if (idx == `IDX_SATURATION)
      rd_byte = sat_reg;
    else if (idx == `IDX_HUE)
      rd_byte = hue_reg;
    else if (idx == `IDX_CONTRAST)
      rd_byte = contrast_reg;
    else if (idx == `IDX_OUTPUT_FORMAT)
      rd_byte = format_reg;
    else if (idx == `IDX_LUMA_CTL_THREE)
      rd_byte = luma_three_reg;
    else if (idx == `IDX_SHARED_PIN)
      rd_byte = shared_reg;
    else if (idx == `IDX_CROP_START_HIGH)
      rd_byte = crop_high_reg;
    else if (idx == `IDX_CROP_START_LOW)
      rd_byte = crop_low_reg;
    else if (idx == `IDX_BLANK_START)
      rd_byte = blank_start_reg;
    else if (idx == `IDX_BLANK_STOP)
      rd_byte = blank_stop_reg;
    else if (idx == `IDX_NOTCH_WIDTH)
      rd_byte = notch_width_reg;
    else
      rd_byte = 8'h00;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Adjusted vertical blanking window from signed line offsets
  wire signed [LINE_W+1:0] win_start =
    $signed({2'b00, std_blank_start_i}) + $signed({{(LINE_W-6){blank_start_reg[7]}},
    blank_start_reg});
  wire signed [LINE_W+1:0] win_stop =
    $signed({2'b00, std_blank_stop_i}) + $signed({{(LINE_W-6){blank_stop_reg[7]}},
    blank_stop_reg});
  wire signed [LINE_W+1:0] line_s = $signed({2'b00, line_i});
  wire in_blank = (line_s >= win_start) && (line_s < win_stop);

  wire luma_2x_mode = luma_one_reg[`BIT_LUMA_2X] |
                      (luma_one_reg[`BIT_BLANK_BYPASS] & in_blank);

  // Luma and chroma delay lines; chroma is fixed at the centre tap
  reg [7:0] luma_line [0:`DELAY_TAPS-1];
  reg [7:0] chroma_line [0:`DELAY_TAPS-1];
  genvar g;
  generate
    for (g = 0; g < `DELAY_TAPS; g = g + 1) begin : dly
      always @(posedge clk_i) begin
        if (rst_i) begin
          luma_line[g]   <= 8'h00;
          chroma_line[g] <= 8'h00;
        end else if (g == 0) begin
          luma_line[g]   <= luma_i;
          chroma_line[g] <= chroma_i;
        end else begin
          luma_line[g]   <= luma_line[g-1];
          chroma_line[g] <= chroma_line[g-1];
        end
      end
    end
  endgenerate

  // Negative codes count down from 1000 = -1 to 1111 = -8, so invert the magnitude
  wire [3:0] luma_tap = luma_one_reg[3] ? {1'b0, ~luma_one_reg[2:0]} :
                                          {1'b1, luma_one_reg[2:0]};
  wire [7:0] luma_d   = luma_line[luma_tap];
  wire [7:0] chroma_d = chroma_line[`DELAY_CENTRE];

  // Picture adjustment: 128 is unity contrast and saturation, zero brightness
  wire [15:0]        y_prod   = luma_d * contrast_reg;
  wire signed [10:0] y_adj    = $signed({2'b00, y_prod[15:7]}) +
                                $signed({3'b000, bright_reg}) -
                                $signed({3'b000, `CHROMA_OFFSET});
  wire signed [16:0] c_prod   = $signed(chroma_d) * $signed({1'b0, sat_reg});
  wire signed [10:0] c_scaled = $signed(c_prod[16:6]) >>> 1;
  wire signed [10:0] c_code   = c_scaled + $signed({3'b000, `CHROMA_OFFSET});

  wire       ext_range = format_reg[`BIT_EXT_RANGE];
  wire [7:0] y_lo = ext_range ? `CODE_MIN_WIDE : `Y_MIN_NARROW;
  wire [7:0] y_hi = ext_range ? `CODE_MAX_WIDE : `Y_MAX_NARROW;
  wire [7:0] c_lo = ext_range ? `CODE_MIN_WIDE : `C_MIN_NARROW;
  wire [7:0] c_hi = ext_range ? `CODE_MAX_WIDE : `C_MAX_NARROW;

  function [7:0] clip;
    input signed [10:0] v;
    input [7:0]         lo;
    input [7:0]         hi;
    begin
      if (v < $signed({3'b000, lo}))
        clip = lo;
      else if (v > $signed({3'b000, hi}))
        clip = hi;
      else
        clip = v[7:0];
    end
  endfunction

  wire [7:0] y_out = clip(y_adj, y_lo, y_hi);
  wire [7:0] c_off = clip(c_code, c_lo, c_hi);
  // Plain two's complement is the offset code with its top bit flipped
  wire [7:0] c_out = format_reg[`BIT_PLAIN_TWOS] ? (c_off ^ `CHROMA_OFFSET) : c_off;

  wire [1:0] path = format_reg[4:3];
  wire [2:0] fmt  = format_reg[2:0];

  // Output stream; the header slot wins over every data path
  always @(posedge clk_i) begin
    if (rst_i) begin
      pixel_y_o        <= 8'h00;
      pixel_c_o        <= 8'h00;
      luma_2x_active_o <= 1'b0;
    end else begin
      luma_2x_active_o <= luma_2x_mode;
      if (anc_slot_i) begin
        pixel_y_o <= luma_one_reg[`BIT_RAW_HEADER_OFF] ?
                     `DUMMY_HEADER : anc_header_i;
        pixel_c_o <= luma_one_reg[`BIT_RAW_HEADER_OFF] ?
                     `DUMMY_HEADER : anc_header_i;
      end else if (path == `PATH_DECIMATED) begin
        pixel_y_o <= horizontal_blank_region_i ? `BLANK_LUMA : decimated_i;
        pixel_c_o <= horizontal_blank_region_i ? `CHROMA_OFFSET : decimated_i;
      end else if (path == `PATH_RAW) begin
        pixel_y_o <= raw_sample_i;
        pixel_c_o <= raw_sample_i;
      end else if (luma_2x_mode) begin
        pixel_y_o <= luma_d;
        pixel_c_o <= luma_2x_i;
      end else begin
        pixel_y_o <= y_out;
        pixel_c_o <= c_out;
      end
    end
  end

  // Shared pins, filter controls and derived levels
  wire combined_lock = lock_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      embedded_sync_o         <= 1'b1;
      format_reserved_o       <= 1'b0;
      active_video_flag_o     <= 1'b0;
      field_identifier_out_o  <= 1'b0;
      pal_indicator_out_o     <= 1'b0;
      interrupt_request_out_o <= 1'b0;
      peaking_gain_o          <= 3'h0;
      trap_filter_o           <= 1'b0;
      agc_force_o             <= 1'b0;
      agc_force_on_o          <= 1'b0;
      notch_select_o          <= 2'h0;
      wide_notch_select_o     <= 1'b0;
      pedestal_present_o      <= 1'b0;
      hue_phase_o             <= 8'h00;
      vertical_blank_out_o    <= 1'b0;
    end else begin
      embedded_sync_o   <= (fmt == `FMT_EMBEDDED_SYNC);
      format_reserved_o <= ((fmt != `FMT_EMBEDDED_SYNC) && (fmt != `FMT_DISCRETE_SYNC))
                           || (path == 2'h3);
      active_video_flag_o <= active_video_i &
        ~(crop_low_reg[`BIT_FLAG_OFF_IN_BLANK] & in_blank);
      if (shared_reg[`BIT_PIN_A_GENLOCK])
        field_identifier_out_o <= genlock_i;
      else if (shared_reg[`BIT_PIN_A_LOCK])
        field_identifier_out_o <= combined_lock;
      else
        field_identifier_out_o <= field_id_i;
      if (!shared_reg[`BIT_PIN_B_PAL])
        pal_indicator_out_o <= vsync_i;
      else if (shared_reg[`BIT_PIN_B_LOCK])
        pal_indicator_out_o <= combined_lock;
      else
        pal_indicator_out_o <= pal_i;
      if (!shared_reg[`BIT_PIN_C_ALT])
        interrupt_request_out_o <= irq_i;
      else if (misc_pin_reg[`BIT_PIN_C_BLANK])
        interrupt_request_out_o <= in_blank;
      else
        interrupt_request_out_o <= gp_level_i;
      case (luma_two_reg[3:2])
        2'h0: peaking_gain_o <= 3'h0;
        2'h1: peaking_gain_o <= 3'h1;
        2'h2: peaking_gain_o <= 3'h2;
        default: peaking_gain_o <= 3'h4;
      endcase
      trap_filter_o  <= luma_two_reg[`BIT_TRAP_SELECT];
      agc_force_o    <= luma_two_reg[1];
      agc_force_on_o <= luma_two_reg[1] & luma_two_reg[0];
      notch_select_o      <= luma_three_reg[1:0];
      wide_notch_select_o <= notch_width_reg[`BIT_WIDE_NOTCH];
      pedestal_present_o  <= ~luma_one_reg[`BIT_NO_PEDESTAL];
      hue_phase_o          <= secam_i ? 8'h00 : hue_reg;
      vertical_blank_out_o <= in_blank;
    end
  end

  // Clock pin is a pure mux so the output keeps the source clock's shape
  assign clock_out_o = shared_reg[`BIT_CLOCK_1X] ? clk_1x_i : clk_2x_i;

endmodule // pixel_control_regs

// ==== shared/pixel_control_regs.vh ====
// Register indices, field positions, reset values and timing for the pixel control bank
`ifndef PIXEL_CONTROL_REGS_VH
`define PIXEL_CONTROL_REGS_VH

// Register indices; byte address on the bus is four times the index
`define IDX_MISC_PIN_SELECT     5'h03
`define IDX_LUMA_CTL_ONE        5'h07
`define IDX_LUMA_CTL_TWO        5'h08
`define IDX_BRIGHTNESS          5'h09
`define IDX_SATURATION          5'h0a
`define IDX_HUE                 5'h0b
`define IDX_CONTRAST            5'h0c
`define IDX_OUTPUT_FORMAT       5'h0d
`define IDX_LUMA_CTL_THREE      5'h0e
`define IDX_SHARED_PIN          5'h0f
`define IDX_CROP_START_HIGH     5'h11
`define IDX_CROP_START_LOW      5'h12
`define IDX_BLANK_START         5'h18
`define IDX_BLANK_STOP          5'h19
`define IDX_NOTCH_WIDTH         5'h1b

// Reset values
`define RST_MISC_PIN_SELECT     8'h00
`define RST_LUMA_CTL_ONE        8'h60
`define RST_LUMA_CTL_TWO        8'h00
`define RST_BRIGHTNESS          8'h80
`define RST_SATURATION          8'h80
`define RST_HUE                 8'h00
`define RST_CONTRAST            8'h80
`define RST_OUTPUT_FORMAT       8'h47
`define RST_LUMA_CTL_THREE      8'h00
`define RST_SHARED_PIN          8'h08
`define RST_CROP_START_HIGH     8'h00
`define RST_CROP_START_LOW      8'h00
`define RST_BLANK_START         8'h00
`define RST_BLANK_STOP          8'h00
`define RST_NOTCH_WIDTH         8'h00

// Luma control one fields
`define BIT_LUMA_2X             7
`define BIT_NO_PEDESTAL         6
`define BIT_RAW_HEADER_OFF      5
`define BIT_BLANK_BYPASS        4
// Luma control two fields
`define BIT_TRAP_SELECT         6
// Output format fields
`define BIT_EXT_RANGE           6
`define BIT_PLAIN_TWOS          5
`define PATH_NORMAL             2'h0
`define PATH_DECIMATED          2'h1
`define PATH_RAW                2'h2
`define FMT_DISCRETE_SYNC       3'h0
`define FMT_EMBEDDED_SYNC       3'h7
// Shared pin fields
`define BIT_PIN_A_LOCK          6
`define BIT_PIN_B_LOCK          4
`define BIT_PIN_A_GENLOCK       3
`define BIT_PIN_B_PAL           2
`define BIT_PIN_C_ALT           1
`define BIT_CLOCK_1X            0
// Other fields
`define BIT_FLAG_OFF_IN_BLANK   2
`define BIT_PIN_C_BLANK         7
`define BIT_WIDE_NOTCH          2

// Code levels
`define DUMMY_HEADER            8'h40
`define CHROMA_OFFSET           8'h80
`define UNITY_GAIN_SHIFT        7
`define Y_MIN_NARROW            8'h10
`define Y_MAX_NARROW            8'heb
`define C_MIN_NARROW            8'h10
`define C_MAX_NARROW            8'hf0
`define CODE_MIN_WIDE           8'h01
`define CODE_MAX_WIDE           8'hfe
`define BLANK_LUMA              8'h10

// Luma to chroma delay line
`define DELAY_TAPS              16
`define DELAY_CENTRE            8

`endif

// ==== verification/pixel_control_regs_assertions.sv ====
// Concurrent checks on the bank's bus answers and derived outputs
`timescale 1ns/1ps
module pixel_control_regs_checker (
  input wire        clk_i,             // Clock
  input wire        rst_i,             // Reset
  input wire        wb_cyc_i,          // Cycle
  input wire        wb_stb_i,          // Strobe
  input wire        wb_we_i,           // Write
  input wire [6:0]  wb_adr_i,          // Address
  input wire [3:0]  wb_sel_i,          // Selects
  input wire [31:0] wb_dat_o,          // Read data
  input wire        wb_ack_o,          // Ack
  input wire [9:0]  crop_start_o,      // Crop start
  input wire [2:0]  peaking_gain_o,    // Gain
  input wire        agc_force_o,       // Forced
  input wire        agc_force_on_o,    // Forced on
  input wire        embedded_sync_o,   // Embedded
  input wire        format_reserved_o  // Reserved
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire low_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i[6:2] == 5'h12;
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_after_take: assert property (take_s |=> answer_s)
    else $error("request not answered in one cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  a_crop_on_low: assert property (!$stable(crop_start_o) |-> $past(low_wr))
    else $error("crop start moved without low write");
  a_gain_legal: assert property (peaking_gain_o inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("peaking gain not a legal step");
  a_agc_on_forced: assert property (agc_force_on_o |-> agc_force_o)
    else $error("forced-on without forcing");
  a_format_excl: assert property (embedded_sync_o |-> !format_reserved_o)
    else $error("embedded format flagged reserved");
endmodule // pixel_control_regs_checker
bind pixel_control_regs pixel_control_regs_checker chk_u (.*);

// ==== verification/pixel_control_regs_tb.sv ====
// Self-checking bench for the pixel control register bank
`timescale 1ns/1ps
module pixel_control_regs_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, anc_slot_i = 0;
  logic horizontal_blank_region_i = 0, secam_i = 0, active_video_i = 0, field_id_i = 0;
  logic genlock_i = 0, lock_i = 0, vsync_i = 0, pal_i = 0, irq_i = 0, gp_level_i = 0;
  logic clk_2x_i = 0, clk_1x_i = 0, wb_ack_o, luma_2x_active_o, embedded_sync_o;
  logic format_reserved_o, active_video_flag_o, field_identifier_out_o, pal_indicator_out_o;
  logic interrupt_request_out_o, clock_out_o, trap_filter_o, agc_force_o, agc_force_on_o;
  logic wide_notch_select_o, pedestal_present_o, vertical_blank_out_o;
  logic [1:0] notch_select_o;
  logic [2:0] peaking_gain_o;
  logic [3:0] wb_sel_i = 0;
  logic [6:0] wb_adr_i = 0;
  logic [7:0] luma_i = 0, chroma_i = 0, luma_2x_i = 0, decimated_i = 0, raw_sample_i = 0;
  logic [7:0] anc_header_i = 8'ha5, pixel_y_o, pixel_c_o, hue_phase_o, q;
  logic [9:0] line_i = 0, std_blank_start_i = 0, std_blank_stop_i = 0, crop_start_o;
  logic [15:0] word;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic [87:0] idx_tab = 88'h07_08_09_0a_0b_0c_0d_0e_0f_11_12;
  logic [87:0] rst_tab = 88'h60_00_80_80_00_80_47_00_08_00_00;
  int fails = 0, check_count = 0;
  pixel_control_regs dut_u (.*);
  video_capture_host host_u (.clk_i(clk_i), .y_i(pixel_y_o), .c_i(pixel_c_o), .word_o(word));
  initial forever #25 clk_i = ~clk_i;
  always #7 clk_2x_i = ~clk_2x_i;
  always #14 clk_1x_i = ~clk_1x_i;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(input logic we, input logic [4:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'h1};
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task t_defaults;
    for (int i = 0; i < 11; i++) begin
      bus(0, idx_tab[8*i+:5], 8'h0);
      chk("reset value", rst_tab[8*i+:8], q);
      bus(1, idx_tab[8*i+:5], ~rst_tab[8*i+:8]);
      bus(0, idx_tab[8*i+:5], 8'h0);
      chk("readback", {~rst_tab[8*i+:8]}, q);
      bus(1, idx_tab[8*i+:5], rst_tab[8*i+:8]);
    end
    bus(0, 5'h1f, 8'h0);
    chk("unmapped", 0, q);
    tick(2);
    chk("pedestal", 0, pedestal_present_o);
    chk("embedded", 1, embedded_sync_o);
    $display("defaults done");
  endtask
  task t_crop;
    bus(1, 5'h11, 8'h80);
    tick(2);
    chk("crop staged", 0, crop_start_o);
    bus(1, 5'h12, 8'h03);
    tick(2);
    chk("crop applied", 10'h203, crop_start_o);
    $display("crop done");
  endtask
  task t_header;
    @(posedge clk_i);
    anc_slot_i <= 1;
    tick(3);
    chk("dummy header", 16'h4040, word);
    bus(1, 5'h07, 8'h40);
    tick(3);
    chk("real header", 16'ha5a5, word);
    @(posedge clk_i);
    anc_slot_i <= 0;
    $display("header done");
  endtask
  task t_luma_two;
    for (int k = 0; k < 4; k++) begin
      bus(1, 5'h08, {4'b0100, k[1:0], k[1:0]});
      tick(2);
      chk("gain", k == 3 ? 4 : k, peaking_gain_o);
      chk("agc", {k[1], k == 3}, {agc_force_o, agc_force_on_o});
      chk("trap", 1, trap_filter_o);
    end
    $display("luma two done");
  endtask
  task t_pins;
    @(posedge clk_i);
    {genlock_i, pal_i, gp_level_i, field_id_i, vsync_i, irq_i} <= 6'b111000;
    bus(1, 5'h0f, 8'h0e);
    tick(2);
    chk("pins alt", 3'b111, {field_identifier_out_o, pal_indicator_out_o,
      interrupt_request_out_o});
    bus(1, 5'h0f, 8'h00);
    tick(2);
    chk("pins main", 3'b000, {field_identifier_out_o, pal_indicator_out_o,
      interrupt_request_out_o});
    $display("pins done");
  endtask
  task t_misc;
    bus(1, 5'h0e, 8'h03);
    bus(1, 5'h1b, 8'h04);
    bus(1, 5'h0b, 8'h7f);
    tick(2);
    chk("notch", 3'h7, {notch_select_o, wide_notch_select_o});
    chk("hue", 8'h7f, hue_phase_o);
    @(posedge clk_i);
    secam_i <= 1;
    tick(2);
    chk("hue secam", 0, hue_phase_o);
    bus(1, 5'h0d, 8'h58);
    tick(2);
    chk("reserved", 2'b10, {format_reserved_o, embedded_sync_o});
    bus(1, 5'h0d, 8'h47);
    bus(1, 5'h0f, 8'h09);
    tick(1);
    #0.5;
    chk("clock pin", clk_1x_i, clock_out_o);
    bus(1, 5'h07, 8'h80);
    @(posedge clk_i);
    luma_2x_i <= 8'h3c;
    tick(3);
    chk("luma 2x", 9'h13c, {luma_2x_active_o, pixel_c_o});
    $display("misc done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_defaults;
    t_crop;
    t_header;
    t_luma_two;
    t_pins;
    t_misc;
    final_report;
  end
  initial begin
    #100000;
    fails++;
    final_report;
  end
endmodule // pixel_control_regs_tb

// ==== verification/video_capture_host.sv ====
// Capture host model sinking the decoded byte pairs
`timescale 1ns/1ps
module video_capture_host (
  input  wire         clk_i,  // Pixel clock
  input  wire  [7:0]  y_i,    // Luma byte
  input  wire  [7:0]  c_i,    // Chroma byte
  output logic [15:0] word_o  // Last captured pair
);
  // Host only latches; the bench judges the pair
  always @(posedge clk_i) word_o <= {y_i, c_i};
endmodule // video_capture_host
